// ==== verif/charger_control_and_irq_bench.sv ====
// Purpose: self-checking bench for the charger control block
// Assumes: short tick and minute counts set by parameters
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module charger_control_and_irq_bench;
  import chc_pkg::*;
  typedef struct packed { logic [7:0] a; logic [7:0] e; } chc_row_t;
  logic       core_clk, rst_n, chargeActive, ledSinkOn, irqOut, irqOeN;
  logic       wakeOut, wakeOeN, irqN;
  logic [7:0] regRdData;
  logic [2:0] topoffThr;
  chc_state_t chargeMode;
  chc_req_t   regReq;
  chc_ana_t   ana;
  int         miscompares = 0;
  int         check_count = 0;
  int         cyc = 0;
  // register offset beside the value read back
  localparam chc_row_t ROWS [6] = '{'{8'h04, 8'h40}, '{8'h03, 8'h08},
    '{8'h0b, 8'h80}, '{8'h0a, 8'h00}, '{8'h07, 8'h00}, '{8'h09, 8'h01}};

  chc_charger_ctrl #(.TICK_CYCLES(2), .MINUTE_TICKS(20), .RECON_UNDERVOLTAGE_LOCKOUT(1'b0))
  chc_charger_ctrl_i (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .regReq      (regReq),
    .ana         (ana),
    .regRdData   (regRdData),
    .chargeActive(chargeActive),
    .chargeMode  (chargeMode),
    .topoffThr   (topoffThr),
    .ledSinkOn   (ledSinkOn),
    .irqOut      (irqOut),
    .irqOeN      (irqOeN),
    .wakeOut     (wakeOut),
    .wakeOeN     (wakeOeN)
  );

  chc_host_model chc_host_model_i (
    .core_clk (core_clk),
    .regRdData(regRdData),
    .irqOut   (irqOut),
    .irqOeN   (irqOeN),
    .regReq   (regReq),
    .irqN     (irqN)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    chc_host_model_i.access(a, 8'h00, 1'b0, q);
    `CHK(q, e)
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    chc_host_model_i.access(a, d, 1'b1, q);
  endtask : wr

  // hang guard
  initial begin
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 20000) begin
        miscompares++;
        close_out();
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    ana = '0;
    ana.inhibitPin = 1'b1;
    ana.batAboveUvlo = 1'b1;
    wt(20);
    rst_n = 1'b1;
    `CHK(ledSinkOn, 1'b1)
    `CHK(irqN, 1'b1)
    wt(3);
    ana.chargerPresent = 1'b1;
    wt(5);
    `CHK(chargeActive, 1'b0)
    `CHK(wakeOeN, 1'b1)
    ana.inhibitPin = 1'b0;
    wt(5);
    `CHK(chargeActive, 1'b1)
    `CHK(irqN, 1'b1)
    wt(40);
    `CHK(wakeOeN, 1'b0)
    foreach (ROWS[i]) rd(ROWS[i].a, ROWS[i].e);
    `CHK(wakeOeN, 1'b1)
    ana.inhibitPin = 1'b1;
    wt(5);
    `CHK(chargeActive, 1'b1)
    `CHK(irqN, 1'b0)
    rd(8'h03, 8'h08);
    rd(8'h04, 8'h00);
    `CHK(irqN, 1'b1)
    // overvoltage must persist before the charger is cut
    ana.ovpDetect = 1'b1;
    wt(600);
    `CHK(chargeActive, 1'b1)
    wt(60);
    `CHK(chargeActive, 1'b0)
    rd(8'h03, 8'h10);
    ana.inhibitPin = 1'b0;
    wt(5);
    `CHK(irqN, 1'b1)
    rd(8'h04, 8'h00);
    wt(3);
    `CHK(irqN, 1'b0)
    rd(8'h03, 8'h08);
    rd(8'h04, 8'h00);
    ana.ovpDetect = 1'b0;
    wt(5);
    `CHK(chargeActive, 1'b1)
    // top-off then done with restart off
    wr(8'h09, 8'h03);
    ana.vsetReached = 1'b1;
    wt(5);
    `CHK(topoffThr, 3'h1)
    `CHK(chargeMode, CS_TOPOFF)
    ana.currentBelowThr = 1'b1;
    wt(5);
    `CHK(chargeMode, CS_DONE)
    `CHK(chargeActive, 1'b0)
    `CHK(irqN, 1'b0)
    rd(8'h03, 8'h21);
    rd(8'h04, 8'h00);
    rd(8'h09, 8'h02);
    `CHK(irqN, 1'b1)
    wr(8'h0b, 8'h00);
    wt(2);
    `CHK(ledSinkOn, 1'b0)
    // endless top-off: safety expiry first, then the watchdog cuts it
    wr(8'h0a, 8'h03);
    wr(8'h0b, 8'h01);
    wr(8'h09, 8'h01);
    wt(9800);
    `CHK(chargeMode, CS_TOPOFF)
    `CHK(chargeActive, 1'b1)
    `CHK(irqN, 1'b0)
    wt(400);
    `CHK(chargeActive, 1'b0)
    rd(8'h03, 8'h26);
    rd(8'h04, 8'h00);
    rd(8'h09, 8'h00);
    // reset in mid-run, then timer-only done and reconnect
    rst_n = 1'b0;
    wt(2);
    rst_n = 1'b1;
    `CHK(ledSinkOn, 1'b1)
    rd(8'h09, 8'h01);
    wr(8'h09, 8'h21);
    wt(300);
    `CHK(chargeMode, CS_TOPOFF)
    wt(400);
    `CHK(chargeMode, CS_DONE)
    ana.inhibitPin = 1'b1;
    ana.chargerPresent = 1'b0;
    wt(2);
    ana.chargerPresent = 1'b1;
    wt(5);
    `CHK(chargeMode, CS_OFF)
    close_out();
  end
endmodule : charger_control_and_irq_bench

// ==== verif/chc_host_model.sv ====
// Purpose: host processor model on the charger register port
// Assumes: requests launched on the falling edge, one cycle wide
// Notes:   interrupt wire has a pull-up when nobody drives it
`timescale 1ns/1ps
module chc_host_model
  import chc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData,
  input  wire logic       irqOut,
  input  wire logic       irqOeN,
  output chc_req_t        regReq,
  output logic            irqN
);
  // pull-up on the open-drain line
  assign irqN = irqOeN ? 1'b1 : irqOut;

  initial regReq = '0;

  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w, output logic [7:0] q);
    @(negedge core_clk);
    regReq = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge core_clk);
    regReq = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    q = regRdData;
  endtask : access
endmodule : chc_host_model

// ==== verilog/chc_charger_ctrl.sv ====
// Purpose: charger sequencing, enable arbitration, events and wake output
// Assumes: register strobes are one-cycle pulses from the serial decoder
// Notes:   open-drain pins are driven low while their enable is low
`timescale 1ns/1ps
module chc_charger_ctrl
  import chc_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYC,
  parameter int MINUTE_TICKS = MIN_MS,
  parameter bit RECON_UNDERVOLTAGE_LOCKOUT   = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire chc_req_t    regReq,
  input  wire chc_ana_t    ana,
  output logic [7:0]       regRdData,
  output logic             chargeActive,
  output chc_state_t       chargeMode,
  output logic [THR_W-1:0] topoffThr,
  output logic             ledSinkOn,
  output logic             irqOut,
  output logic             irqOeN,
  output logic             wakeOut,
  output logic             wakeOeN
);

  chc_st_t       s_r;
  chc_st_t       s_nxt;
  logic [NT-1:0] tRun;
  logic [NT-1:0] tExp;
  logic [TW-1:0] tLim [NT];
  logic          tick;
  logic          acc3;
  logic          acc4;
  logic          acc9;
  logic          accA;
  logic          wr9;
  logic          rdEvA;
  logic          charging;
  logic          doneQual;
  logic          inRead;
  logic          safeEdge;
  logic          wakeSrc;
  logic [7:0]    newA;
  logic [7:0]    newB;

  assign tick     = (s_r.tickCnt == 14'(TICK_CYCLES - 1));
  assign acc3     = (regReq.rd | regReq.wr) && (regReq.addr == OFS_EVT_A);
  assign acc4     = (regReq.rd | regReq.wr) && (regReq.addr == OFS_EVT_B);
  assign acc9     = (regReq.rd | regReq.wr) && (regReq.addr == OFS_CTRL_A);
  assign accA     = (regReq.rd | regReq.wr) && (regReq.addr == OFS_CTRL_B);
  assign wr9      = regReq.wr && (regReq.addr == OFS_CTRL_A);
  assign rdEvA    = regReq.rd && (regReq.addr == OFS_EVT_A);
  assign charging = (s_r.state == CS_FAST) || (s_r.state == CS_TOPOFF);
  assign inRead   = s_r.rdA | s_r.rdB;
  assign safeEdge = tExp[T_SAFE] && !s_r.safeHit;
  assign wakeSrc  = tExp[T_DEB] && ana.batAboveUvlo;

  assign doneQual = (s_r.state == CS_TOPOFF) &&
    (((s_r.ctrlA[CA_THR +: THR_W] != '0) && ana.currentBelowThr) ||
     tExp[T_TOP]);

  always_comb begin
    tRun[T_WDOG]  = s_r.regCtrl[RC_WATCHDOG_ENABLE_BIT] && s_r.chgOn && !(acc9 || accA);
    tRun[T_SAFE]  = charging && !s_r.safeHit;
    // top-off timer off at code zero
    tRun[T_TOP]   = (s_r.state == CS_TOPOFF) &&
                    (s_r.ctrlA[CA_TOP +: 2] != 2'h0);
    tRun[T_GRACE] = s_r.graceRun;
    tRun[T_OVP]   = ana.ovpDetect && !s_r.ovpShut;
    tRun[T_DEB]   = ana.chargerPresent;
    tLim[T_WDOG]  = TW'(WDOG_MS);
    tLim[T_SAFE]  = TW'(int'(SAFE_MIN[s_r.ctrlB[CB_SAFE +: 2]]) *
                        MINUTE_TICKS);
    tLim[T_TOP]   = TW'(int'(TOP_MIN[s_r.ctrlA[CA_TOP +: 2]]) *
                        MINUTE_TICKS);
    tLim[T_GRACE] = TW'(GRACE_MS);
    tLim[T_OVP]   = TW'(OVP_MS);
    tLim[T_DEB]   = TW'(WDEB_MS);
  end

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    chc_timer u_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .run      (tRun[i]),
      .limit    (tLim[i]),
      .expired  (tExp[i])
    );
  end

  always_comb begin
    logic       enSrc;
    logic       kill;
    logic       rA;
    logic       rB;
    logic [7:0] evA;
    logic [7:0] evB;
    logic [7:0] pA;
    logic [7:0] pB;
    logic [7:0] status;
    enSrc  = 1'b0;
    kill   = 1'b0;
    rA     = 1'b0;
    rB     = 1'b0;
    evA    = s_r.evtA;
    evB    = s_r.evtB;
    pA     = s_r.pendA;
    pB     = s_r.pendB;
    status = '0;
    newA   = '0;
    newB   = '0;
    s_nxt  = s_r;
    s_nxt.tickCnt = tick ? '0 : s_r.tickCnt + 14'h0001;
    s_nxt.pinLow  = 1'b0;
    s_nxt.primed  = 1'b1;

    newA[EA_PIN]   = s_r.primed && (s_r.pinPrev != ana.inhibitPin);
    s_nxt.pinPrev  = ana.inhibitPin;
    s_nxt.presPrev = ana.chargerPresent;

    if (tExp[T_OVP] && !s_r.ovpShut) begin
      s_nxt.ovpShut = 1'b1;
      newA[EA_OVP]  = 1'b1;
    end else if (!ana.ovpDetect) begin
      s_nxt.ovpShut = 1'b0;
    end

    if (regReq.wr) begin
      case (regReq.addr)
        OFS_CTRL_A:   s_nxt.ctrlA   = regReq.wdata;
        OFS_CTRL_B:   s_nxt.ctrlB   = regReq.wdata;
        OFS_REG_CTRL: s_nxt.regCtrl = regReq.wdata;
        OFS_MASK_A:   s_nxt.maskA   = regReq.wdata;
        OFS_MASK_B:   s_nxt.maskB   = regReq.wdata;
        default:      ;
      endcase
    end

    if (s_r.primed && ana.chargerPresent && !s_r.presPrev &&
        (!RECON_UNDERVOLTAGE_LOCKOUT || !ana.batAboveUvlo)) begin
      s_nxt.override = 1'b0;
    end
    if (acc9) begin
      s_nxt.override = 1'b1;
    end

    if (rdEvA && (s_r.state == CS_DONE)) begin
      kill = 1'b1;
    end
    if (tExp[T_GRACE]) begin
      kill = 1'b1;
      s_nxt.graceRun = 1'b0;
    end
    if (tExp[T_WDOG]) begin
      kill = 1'b1;
      newA[EA_WDOG] = 1'b1;
    end
    // a host write to control A in the same cycle wins
    if (kill && !wr9) begin
      s_nxt.ctrlA[CA_EN] = 1'b0;
      s_nxt.override     = 1'b1;
    end

    if (safeEdge) begin
      s_nxt.safeHit  = 1'b1;
      s_nxt.graceRun = 1'b1;
      newA[EA_SAFE]  = 1'b1;
    end
    if (!s_r.chgOn) begin
      s_nxt.safeHit  = 1'b0;
      s_nxt.graceRun = 1'b0;
    end

    enSrc = s_nxt.override ? s_nxt.ctrlA[CA_EN] : !ana.inhibitPin;
    s_nxt.chgOn = enSrc && ana.chargerPresent && !s_nxt.ovpShut;

    unique case (s_r.state)
      CS_OFF: begin
        if (s_r.chgOn) begin
          s_nxt.state = CS_FAST;
        end
      end
      CS_FAST: begin
        if (ana.vsetReached) begin
          s_nxt.state     = CS_TOPOFF;
          newA[EA_TOPOFF] = 1'b1;
        end
      end
      CS_TOPOFF: begin
        if (doneQual) begin
          s_nxt.state   = CS_DONE;
          newA[EA_DONE] = 1'b1;
        end
      end
      CS_DONE: begin
        if (s_r.ctrlA[CA_RESTART] && ana.batBelowRestart) begin
          s_nxt.state = CS_FAST;
        end
      end
    endcase
    if (!s_r.chgOn) begin
      s_nxt.state = CS_OFF;
    end
    s_nxt.active = (s_nxt.state == CS_FAST) || (s_nxt.state == CS_TOPOFF);

    // event access or safety expiry stops wake
    s_nxt.srcPrev = wakeSrc;
    if (acc3 || acc4 || safeEdge) begin
      s_nxt.wakePend = 1'b0;
    end
    if (s_r.primed && wakeSrc && !s_r.srcPrev) begin
      s_nxt.wakePend = 1'b1;
      newB[EB_DET]   = 1'b1;
    end
    if (!s_nxt.wakePend) begin
      s_nxt.phase = '0;
    end else if (tick) begin
      s_nxt.phase = (s_r.phase == WAKE_LAST) ? '0 : s_r.phase + 6'h01;
    end
    s_nxt.wakeOeN = !(s_nxt.wakePend && (s_nxt.phase < WAKE_ON));

    if (acc3) begin
      evA = '0;
    end
    if (acc4) begin
      evB = '0;
    end
    if (acc3 || safeEdge) begin
      evB[EB_DET] = 1'b0;
    end
    if (inRead || acc3 || acc4) begin
      pA = pA | newA;
      pB = pB | newB;
    end else begin
      evA = evA | newA;
      evB = evB | newB;
    end
    rA = s_r.rdA | acc3;
    rB = s_r.rdB | acc4;
    if (rA && rB) begin
      evA = evA | pA;
      evB = evB | pB;
      pA  = '0;
      pB  = '0;
      rA  = 1'b0;
      rB  = 1'b0;
      s_nxt.puMask = 1'b0;
    end
    s_nxt.evtA  = evA;
    s_nxt.evtB  = evB;
    s_nxt.pendA = pA;
    s_nxt.pendB = pB;
    s_nxt.rdA   = rA;
    s_nxt.rdB   = rB;
    s_nxt.irqOeN = !((((evA & ~s_nxt.maskA) | (evB & ~s_nxt.maskB)) != '0)
                     && !s_nxt.puMask);

    status[SB_PIN]  = ana.inhibitPin;
    status[SB_PRES] = ana.chargerPresent;
    status[SB_DONE] = s_r.state == CS_DONE;
    status[SB_OVP]  = s_r.ovpShut;
    status[SB_FAST] = s_r.state == CS_FAST;
    if (regReq.rd) begin
      case (regReq.addr)
        OFS_STATUS:   s_nxt.rdData = status;
        OFS_EVT_A:    s_nxt.rdData = s_r.evtA;
        OFS_EVT_B:    s_nxt.rdData = s_r.evtB;
        OFS_MASK_A:   s_nxt.rdData = s_r.maskA;
        OFS_MASK_B:   s_nxt.rdData = s_r.maskB;
        OFS_CTRL_A:   s_nxt.rdData = s_r.ctrlA;
        OFS_CTRL_B:   s_nxt.rdData = s_r.ctrlB;
        OFS_REG_CTRL: s_nxt.rdData = s_r.regCtrl;
        default:      s_nxt.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= CHC_ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData    = s_r.rdData;
  assign chargeActive = s_r.active;
  assign chargeMode   = s_r.state;
  assign topoffThr    = s_r.ctrlA[CA_THR +: THR_W];
  assign ledSinkOn    = s_r.regCtrl[RC_LED];
  assign irqOut       = s_r.pinLow;
  assign irqOeN       = s_r.irqOeN;
  assign wakeOut      = s_r.pinLow;
  assign wakeOeN      = s_r.wakeOeN;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_done_qual;
    s_r.state == CS_TOPOFF && !doneQual |=> s_r.state != CS_DONE;
  endproperty
  a_done_qual: assert property (p_done_qual)
    else $error("done without qualification");

  property p_zero_thr;
    s_r.state == CS_TOPOFF && s_r.chgOn && tExp[T_TOP] |=>
      s_r.state == CS_DONE;
  endproperty
  a_zero_thr: assert property (p_zero_thr)
    else $error("top-off timeout did not end charge");

  property p_no_auto_done;
    s_r.ctrlA[CA_THR +: THR_W] == '0 && s_r.ctrlA[CA_TOP +: 2] == 2'h0
      && s_r.state == CS_TOPOFF |=> s_r.state != CS_DONE;
  endproperty
  a_no_auto_done: assert property (p_no_auto_done)
    else $error("automatic done with timer off");

  property p_restart;
    s_r.state == CS_DONE && s_r.chgOn && s_r.ctrlA[CA_RESTART] &&
      ana.batBelowRestart |=> s_r.state == CS_FAST;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart missed");

  property p_no_restart;
    s_r.state == CS_DONE && !s_r.ctrlA[CA_RESTART] |=> !chargeActive;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("charging after done without restart");

  property p_done_read;
    rdEvA && s_r.state == CS_DONE && !regReq.wr |=>
      !s_r.ctrlA[CA_EN] ##1 (!s_r.chgOn || $past(wr9));
  endproperty
  a_done_read: assert property (p_done_read)
    else $error("done read did not disable");

  property p_grace;
    tExp[T_GRACE] && !wr9 |=> !s_r.chgOn;
  endproperty
  a_grace: assert property (p_grace)
    else $error("charger on after grace");

  property p_pin_evt;
    s_r.primed && s_r.pinPrev != ana.inhibitPin |=>
      s_r.evtA[EA_PIN] || s_r.pendA[EA_PIN];
  endproperty
  a_pin_evt: assert property (p_pin_evt)
    else $error("pin change lost");

  property p_pin_dis;
    ana.inhibitPin |=> s_r.override || !s_r.chgOn;
  endproperty
  a_pin_dis: assert property (p_pin_dis)
    else $error("pin high did not disable");

  property p_ovp;
    tExp[T_OVP] && !s_r.ovpShut |=> s_r.ovpShut && !s_r.chgOn;
  endproperty
  a_ovp: assert property (p_ovp)
    else $error("overvoltage did not power down");

  property p_pumask;
    s_r.puMask |-> irqOeN;
  endproperty
  a_pumask: assert property (p_pumask)
    else $error("interrupt during power-up mask");

  property p_hold;
    inRead && newA != '0 |=> (s_r.pendA | s_r.evtA) != '0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("event lost during read-out");

  property p_wake_stop;
    (acc3 || acc4) && !tExp[T_DEB] |=> wakeOeN && !s_r.wakePend;
  endproperty
  a_wake_stop: assert property (p_wake_stop)
    else $error("wake not stopped");

  property p_wake_duty;
    $rose(wakeOeN) && s_r.wakePend |-> s_r.phase == WAKE_ON;
  endproperty
  a_wake_duty: assert property (p_wake_duty)
    else $error("wake released at wrong phase");

  property p_wdog_clr;
    !s_r.chgOn |=> !tExp[T_WDOG];
  endproperty
  a_wdog_clr: assert property (p_wdog_clr)
    else $error("watchdog kept count while off");

  c_done: cover property (s_r.state == CS_TOPOFF ##1 s_r.state == CS_DONE);
  c_restart: cover property (s_r.state == CS_DONE ##1 s_r.state == CS_FAST);
  c_wake: cover property (s_r.wakePend && $rose(wakeOeN));
  c_wdog: cover property (tExp[T_WDOG]);

endmodule : chc_charger_ctrl

// ==== verilog/chc_pkg.sv ====
// Purpose: constants and types for the charger control block
// Assumes: core_clk at 10 MHz; register port fed by the serial decoder
// Notes:   all timers count a 1 ms tick
// What this block does
// - top-off threshold is a programmable percentage; 0% leaves only the timer
// - top-off timer programmable or off; 0% and off never ends charge
// - done only on current below threshold or top-off timeout
// - with restart on, battery below restart level after done re-enters fast
// - with restart off, charging stops at done and is not maintained
// - done flags event A and interrupts; reading event A disables charger
// - safety timer expiry flags event A, interrupts, disables 5 s later
// - every charger register returns to default on reset
// - without override, inhibit pin high disables, low enables charging
// - every inhibit pin level change flags event A and interrupts
// - any access to control A makes the pin ignored for enabling
// - charge enable resets to one; host writes zero to avoid enable
// - reconnecting the charger cancels override; one variant only in lockout
// - indicator sink on after reset, then follows regulator control bit 7
// - watchdog enabled starts 5 s on enable; control accesses restart it
// - watchdog expiry flags event A, interrupts, disables the charger
// - input overvoltage held 324 ms powers charger down and flags event A
// - open-drain interrupt driven low for any unmasked event bit
// - event registers clear on read; after reset the interrupt is masked until both are read
// - events during read-out are held and applied after all reads
// - wake on charger detect above lockout, by rising edge
// - pending wake pulses output with 50 ms period, 98% duty
// - access to either event register or safety expiry stops wake
// - wake edge must stay valid through a 10 ms filter
package chc_pkg;

  localparam int CLK_NS     = 100;
  localparam int TICK_NS    = 1000000;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;
  localparam int MIN_MS     = 60000;
  localparam int WDOG_MS    = 5000;
  localparam int GRACE_MS   = 5000;
  localparam int OVP_MS     = 324;
  localparam int WDEB_MS    = 10;
  localparam int WAKE_PER_MS = 50;
  localparam int WAKE_PCT   = 98;
  localparam int WAKE_ON_MS = WAKE_PER_MS * WAKE_PCT / 100;
  localparam logic [5:0] WAKE_LAST = 6'(WAKE_PER_MS - 1);
  localparam logic [5:0] WAKE_ON   = 6'(WAKE_ON_MS);

  localparam int TW = 24;
  localparam int NT = 6;
  localparam int T_WDOG  = 0;
  localparam int T_SAFE  = 1;
  localparam int T_TOP   = 2;
  localparam int T_GRACE = 3;
  localparam int T_OVP   = 4;
  localparam int T_DEB   = 5;

  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_EVT_A    = 8'h03;
  localparam logic [7:0] OFS_EVT_B    = 8'h04;
  localparam logic [7:0] OFS_MASK_A   = 8'h05;
  localparam logic [7:0] OFS_MASK_B   = 8'h06;
  localparam logic [7:0] OFS_CTRL_A   = 8'h09;
  localparam logic [7:0] OFS_CTRL_B   = 8'h0a;
  localparam logic [7:0] OFS_REG_CTRL = 8'h0b;

  localparam logic [7:0] CTRL_A_RST   = 8'h01;
  localparam logic [7:0] REG_CTRL_RST = 8'h80;

  localparam int CA_EN      = 0;
  localparam int CA_THR     = 1;
  localparam int THR_W      = 3;
  localparam int CA_RESTART = 4;
  localparam int CA_TOP     = 5;
  localparam int CB_SAFE    = 0;
  localparam int RC_WATCHDOG_ENABLE_BIT   = 0;
  localparam int RC_LED     = 7;
  localparam int EA_DONE    = 0;
  localparam int EA_SAFE    = 1;
  localparam int EA_WDOG    = 2;
  localparam int EA_PIN     = 3;
  localparam int EA_OVP     = 4;
  localparam int EA_TOPOFF  = 5;
  localparam int EB_DET     = 6;
  localparam int SB_PIN     = 0;
  localparam int SB_PRES    = 1;
  localparam int SB_DONE    = 2;
  localparam int SB_OVP     = 3;
  localparam int SB_FAST    = 4;

  // minutes per select code
  localparam logic [7:0] SAFE_MIN [4] = '{8'h3c, 8'h78, 8'hb4, 8'hf0};
  localparam logic [7:0] TOP_MIN  [4] = '{8'h00, 8'h0f, 8'h1e, 8'h2d};

  typedef enum logic [1:0] {
    CS_OFF    = 2'b00,
    CS_FAST   = 2'b01,
    CS_TOPOFF = 2'b10,
    CS_DONE   = 2'b11
  } chc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } chc_req_t;

  typedef struct packed {
    logic inhibitPin;
    logic chargerPresent;
    logic batAboveUvlo;
    logic ovpDetect;
    logic currentBelowThr;
    logic vsetReached;
    logic batBelowRestart;
  } chc_ana_t;

  typedef struct packed {
    chc_state_t  state;
    logic [7:0]  ctrlA;
    logic [7:0]  ctrlB;
    logic [7:0]  regCtrl;
    logic [7:0]  maskA;
    logic [7:0]  maskB;
    logic [7:0]  evtA;
    logic [7:0]  evtB;
    logic [7:0]  pendA;
    logic [7:0]  pendB;
    logic [7:0]  rdData;
    logic [13:0] tickCnt;
    logic [5:0]  phase;
    logic        rdA;
    logic        rdB;
    logic        puMask;
    logic        override;
    logic        primed;
    logic        pinPrev;
    logic        presPrev;
    logic        srcPrev;
    logic        wakePend;
    logic        ovpShut;
    logic        safeHit;
    logic        graceRun;
    logic        chgOn;
    logic        active;
    logic        irqOeN;
    logic        wakeOeN;
    logic        pinLow;
  } chc_st_t;

  localparam chc_st_t CHC_ST_RST = '{state: CS_OFF, ctrlA: CTRL_A_RST,
    regCtrl: REG_CTRL_RST, puMask: 1'b1, irqOeN: 1'b1, wakeOeN: 1'b1,
    default: '0};

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          expired;
  } chc_tmr_t;

endpackage : chc_pkg

// ==== verilog/chc_timer.sv ====
// Purpose: millisecond interval timer used for every charger timeout
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes:   expired holds while run stays high once limit ticks have passed
`timescale 1ns/1ps
module chc_timer
  import chc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          run,
  input  wire logic [TW-1:0] limit,
  output logic               expired
);

  chc_tmr_t s_r;
  chc_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt.cnt = '0;
    end else if (tick && (s_r.cnt < limit)) begin
      s_nxt.cnt = s_r.cnt + TW'(1);
    end
    s_nxt.expired = run && (s_nxt.cnt >= limit);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;

endmodule : chc_timer
